/* hw/ccdrt_pkg.sv */
/*
  Shared constants for the CCD readout timing controller: frame, line and
  pixel timing counts, sequencer states and line-length figures.
  Assumes a 40 MHz sys_clk; one horizontal cycle is two sys_clk periods.
*/
package ccdrt_pkg;

  // ==========================================================
  // clock and times
  localparam int          SYS_CLK_MHZ        = 40;
  localparam int          XFER_MIN_NS        = 1000;
  localparam int          XFER_CYCLES        = (XFER_MIN_NS * SYS_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // line figures, in horizontal cycles; reset-low and row-transfer counts in sys_clk cycles
  localparam int          LINE_CYCLES_MULTI  = 1036;
  localparam int          LINE_CYCLES_SINGLE = 2072;
  localparam int          ROUTE_DELAY        = 28;
  localparam int          FIRST_DARK_CYCLE   = 10;
  localparam int          FIRST_ACTIVE_CYCLE = 34;
  localparam int          FIRST_OUT_CYCLE    = 68;
  localparam int          CLAMP_START        = 3;
  localparam int          CLAMP_LENGTH       = 28;
  localparam int          RESET_LOW_CYCLES   = 4;
  localparam int          ROW_XFER_CYCLES    = 8;
  localparam int          MULT_STEPS         = 1800;

  // ==========================================================
  // default threshold code and count widths
  localparam int          SAMPLE_W           = 14;
  localparam logic [13:0] THRESHOLD_DEFAULT  = 14'h00B4;
  localparam int          CNT_W              = 12;

  typedef enum logic [2:0]
  {
    CCDRT_IDLE   = 3'b000,
    CCDRT_PDXFER = 3'b001,
    CCDRT_ROWXF  = 3'b011,
    CCDRT_LINE   = 3'b010,
    CCDRT_DONE   = 3'b110
  } ccdrt_state_t;

endpackage

/* hw/ccdrt_route_delay.sv */
/*
  Per-quadrant routing decision delay line.
  Assumes one shift per horizontal cycle, marked by a one-cycle step pulse.
*/
`timescale 1ns/10ps
module ccdrt_route_delay #(
  parameter int DEPTH = 28
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic step,
  input  wire logic decisionIn,
  output logic      decisionOut
);
  import ccdrt_pkg::*;

  initial
  begin
    if (DEPTH < 2)
    begin
      $error("ccdrt_route_delay: DEPTH below 2");
    end
  end

  typedef struct packed
  {
    logic [DEPTH-1:0] taps;
  } ccdrt_dly_t;

  ccdrt_dly_t st;
  ccdrt_dly_t next_st;

  // ==========================================================
  // shift register
  always_comb
  begin
    next_st = st;
    if (step)
    begin
      next_st.taps = {st.taps[DEPTH-2:0], decisionIn};
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign decisionOut = st.taps[DEPTH-1];
endmodule

/* hw/ccdrt_threshold_cmp.sv */
/*
  Threshold comparison of one front-end sample.
  Assumes samples are unsigned codes, larger code means more electrons.
*/
`timescale 1ns/10ps
module ccdrt_threshold_cmp #(
  parameter int WIDTH = 14
) (
  input  wire logic [WIDTH-1:0] sample,
  input  wire logic [WIDTH-1:0] threshold,
  output logic                  toMultiplier
);
  import ccdrt_pkg::*;

  // ==========================================================
  // at or below threshold goes to the multiplier
  assign toMultiplier = (sample <= threshold);
endmodule

/* hw/ccdrt_readout_ctrl.sv */
/*
  Readout timing generator for one quadrant of a switchable-gain interline
  CCD: photodiode transfer, row transfer, horizontal clocking, sense-gate
  timing, per-pixel charge routing and multiplier clocking.
  Assumes level translators to the sensor pins, a front end that presents a
  sample code with a valid strobe once per horizontal cycle, and that gain
  and high levels are set by analog circuits outside this block.
*/
// What this block must do
// - pulse both vertical phase-one gates high at least 1 us, then low
// - row transfers one at a time; horizontal phase-one high, phase-two low
// - keep multiplied average signal at or below 15,000 electrons
// - threshold 180 electrons; above goes low gain, at or below multiplied
// - sense reset high throughout and at least as wide as exit pulse
// - exit gate pulses last at least 12 ns
// - exit gate rises only after phase-one storage has fallen; here exit rises on the same edge as phase one falls
// - apply routing decision exactly 28 cycles after sensing
// - examine every sample and steer switch gates pixel by pixel
// - multiplier: gate two low, gate three clocked; low gain: reverse
// - bypass mode: all low gain, reset held high, exit clocked like phase two
// - drive sense reset low at least once per line transfer
// - multiplier barrier rises after storage peaks, falls before it; here barrier and storage switch on the same edge
// - phase-two barrier and storage fall as phase-one storage rises
// - multiplier high level set per quadrant, shared by both phases
// - keep multiplier gain at most 40 x at 0 degrees C
// - each row has exactly 1,036 cycles, or 2,072 in single mode
// - black clamp starts 3 cycles into the line, lasts 28 cycles
`timescale 1ns/10ps
module ccdrt_readout_ctrl #(
  parameter int ROWS = 1124
) (
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           frameStart,
  input  wire logic                           singleMode,
  input  wire logic                           bypassMode,
  input  wire logic [ccdrt_pkg::SAMPLE_W-1:0] routeThreshold,
  input  wire logic [ccdrt_pkg::SAMPLE_W-1:0] feSample,
  input  wire logic                           feSampleValid,
  output logic                                vert_phase1_top,
  output logic                                vert_phase1_bottom,
  output logic                                vertRowShift,
  output logic                                horiz_store_phase1,
  output logic                                horiz_store_phase2,
  output logic                                horiz_barrier_phase2,
  output logic                                last_horiz_gate,
  output logic                                sense_gate_exit,
  output logic                                sense_gate_reset,
  output logic                                switch_gate_two,
  output logic                                switch_gate_three,
  output logic                                mult_store_phase1,
  output logic                                mult_store_phase2,
  output logic                                mult_barrier_phase1,
  output logic                                mult_barrier_phase2,
  output logic                                blackClamp,
  output logic                                frameBusy
);
  import ccdrt_pkg::*;

  initial
  begin
    if (ROWS < 1 || ROWS > 4095)
    begin
      $error("ccdrt_readout_ctrl: ROWS out of range");
    end
  end

  typedef struct packed
  {
    ccdrt_state_t       state;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   hcycle;
    logic [CNT_W-1:0]   row;
    logic               half;
    logic               bypass;
    logic               v1t;
    logic               v1b;
    logic               vshift;
    logic               h1s;
    logic               h2s;
    logic               h2b;
    logic               hlast;
    logic               exitG;
    logic               rst;
    logic               sw2;
    logic               sw3;
    logic               m1s;
    logic               m2s;
    logic               m1b;
    logic               m2b;
    logic               clamp;
    logic               busy;
  } ccdrt_ctl_t;

  ccdrt_ctl_t st;
  ccdrt_ctl_t next_st;

  logic rawDecision;
  logic delayedDecision;
  logic hStep;

  function automatic logic [CNT_W-1:0] lineLength(input logic single);
    return single ? CNT_W'(LINE_CYCLES_SINGLE) : CNT_W'(LINE_CYCLES_MULTI);
  endfunction

  // ==========================================================
  // sample decision and delay
  // only small packets reach the multiplier
  ccdrt_threshold_cmp #(
    .WIDTH        (SAMPLE_W)
  ) u_cmp (
    .sample       (feSample),
    .threshold    (routeThreshold),
    .toMultiplier (rawDecision)
  );

  // step once per horizontal cycle while clocking a line
  assign hStep = (st.state == CCDRT_LINE) && st.half;

  ccdrt_route_delay #(
    .DEPTH       (ROUTE_DELAY)
  ) u_dly (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .step        (hStep),
    .decisionIn  (rawDecision && feSampleValid && !st.bypass),
    .decisionOut (delayedDecision)
  );

  // ==========================================================
  // sequencer
  always_comb
  begin
    next_st = st;
    next_st.vshift = 1'b0;
    unique case (st.state)
      CCDRT_IDLE:
      begin
        next_st.busy = 1'b0;
        if (frameStart)
        begin
          next_st.state = CCDRT_PDXFER;
          next_st.cnt = '0;
          next_st.row = '0;
          next_st.bypass = bypassMode;
          next_st.busy = 1'b1;
        end
      end
      CCDRT_PDXFER:
      begin
        next_st.v1t = 1'b1;
        next_st.v1b = 1'b1;
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == CNT_W'(XFER_CYCLES))
        begin
          next_st.v1t = 1'b0;
          next_st.v1b = 1'b0;
          next_st.state = CCDRT_ROWXF;
          next_st.cnt = '0;
        end
      end
      CCDRT_ROWXF:
      begin
        next_st.h1s = 1'b1;
        next_st.h2s = 1'b0;
        next_st.h2b = 1'b0;
        next_st.hlast = 1'b0;
        next_st.exitG = 1'b0;
        next_st.sw2 = 1'b0;
        next_st.sw3 = 1'b0;
        // sense reset low for the first 4 cycles of row transfer
        next_st.rst = (st.cnt < CNT_W'(RESET_LOW_CYCLES)) ? 1'b0 : 1'b1;
        next_st.vshift = (st.cnt == '0);
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == CNT_W'(ROW_XFER_CYCLES - 1))
        begin
          next_st.state = CCDRT_LINE;
          next_st.hcycle = '0;
          next_st.half = 1'b0;
        end
      end
      CCDRT_LINE:
      begin
        next_st.half = !st.half;
        next_st.h1s = st.half;
        next_st.h2s = !st.half;
        next_st.h2b = !st.half;
        // last gate falls as packet enters sense gate
        next_st.hlast = !st.half;
        // exit rises on the same edge as phase one falls
        // exit lasts one 25 ns period
        // bypass clocks exit like phase two, reset held high
        next_st.exitG = st.bypass ? !st.half : 1'b0;
        if (!st.bypass && st.half == 1'b0)
        begin
          next_st.exitG = 1'b1;
        end
        // reset high for every exit pulse
        next_st.rst = 1'b1;
        next_st.sw3 = !st.bypass && delayedDecision && !st.half;
        next_st.sw2 = (st.bypass || !delayedDecision) && !st.half;
        // both storage phases share one drive level
        // gain left to the external high level
        // barrier high only inside storage high
        // phase-two pair falls as phase-one storage rises
        next_st.m1s = st.half;
        next_st.m1b = st.half;
        next_st.m2s = !st.half;
        next_st.m2b = !st.half;
        next_st.clamp = (st.hcycle >= CNT_W'(CLAMP_START)) &&
                        (st.hcycle < CNT_W'(CLAMP_START + CLAMP_LENGTH));
        if (st.half)
        begin
          next_st.hcycle = st.hcycle + 1'b1;
          if (st.hcycle == lineLength(singleMode) - 1'b1)
          begin
            next_st.clamp = 1'b0;
            next_st.row = st.row + 1'b1;
            next_st.cnt = '0;
            next_st.state = (st.row == CNT_W'(ROWS - 1)) ? CCDRT_DONE : CCDRT_ROWXF;
          end
        end
      end
      CCDRT_DONE:
      begin
        next_st.h1s = 1'b1;
        next_st.h2s = 1'b0;
        next_st.h2b = 1'b0;
        next_st.hlast = 1'b0;
        next_st.exitG = 1'b0;
        next_st.sw2 = 1'b0;
        next_st.sw3 = 1'b0;
        next_st.m1s = 1'b1;
        next_st.m1b = 1'b1;
        next_st.m2s = 1'b0;
        next_st.m2b = 1'b0;
        next_st.state = CCDRT_IDLE;
      end
      default:
      begin
        next_st.state = CCDRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '{state: CCDRT_IDLE, h1s: 1'b1, m1s: 1'b1, m1b: 1'b1, rst: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // pin outputs straight from the state register
  assign vert_phase1_top      = st.v1t;
  assign vert_phase1_bottom   = st.v1b;
  assign vertRowShift         = st.vshift;
  assign horiz_store_phase1   = st.h1s;
  assign horiz_store_phase2   = st.h2s;
  assign horiz_barrier_phase2 = st.h2b;
  assign last_horiz_gate      = st.hlast;
  assign sense_gate_exit      = st.exitG;
  assign sense_gate_reset     = st.rst;
  assign switch_gate_two      = st.sw2;
  assign switch_gate_three    = st.sw3;
  assign mult_store_phase1    = st.m1s;
  assign mult_store_phase2    = st.m2s;
  assign mult_barrier_phase1  = st.m1b;
  assign mult_barrier_phase2  = st.m2b;
  assign blackClamp           = st.clamp;
  assign frameBusy            = st.busy;
endmodule

/* verification/ccdrt_readout_chk.sv */
/*
  Pin-timing assertions for ccdrt_readout_ctrl.
  Assumes one sys_clk domain and an async active-high reset.
*/
`timescale 1ns/10ps
module ccdrt_readout_chk
  import ccdrt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bypassMode,
  input wire logic vert_phase1_top,
  input wire logic vert_phase1_bottom,
  input wire logic vertRowShift,
  input wire logic horiz_store_phase1,
  input wire logic horiz_store_phase2,
  input wire logic horiz_barrier_phase2,
  input wire logic mult_store_phase1,
  input wire logic mult_store_phase2,
  input wire logic mult_barrier_phase1,
  input wire logic mult_barrier_phase2,
  input wire logic sense_gate_exit,
  input wire logic sense_gate_reset,
  input wire logic switch_gate_two,
  input wire logic switch_gate_three,
  input wire logic frameBusy
);
  // ==========================================================
  // helpers
  int vertHigh;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      vertHigh <= 0;
    else
      vertHigh <= vert_phase1_top ? vertHigh + 1 : 0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence gatesParked;
    (horiz_store_phase1 && !horiz_store_phase2)[*8];
  endsequence
  sequence resetDip;
    ##[0:7] !sense_gate_reset;
  endsequence
  sequence multStepDone;
    $fell(mult_barrier_phase2) && $rose(mult_store_phase1);
  endsequence

  // ==========================================================
  // assertions
  a_vert_pair_equal: assert property (vert_phase1_top == vert_phase1_bottom)
    else $error("vertical gates differ");
  a_vert_pulse_width: assert property ($fell(vert_phase1_top) |-> vertHigh >= XFER_CYCLES)
    else $error("vertical pulse too short");
  a_row_gates_parked: assert property ($rose(vertRowShift) |-> gatesParked)
    else $error("horizontal gates move in row transfer");
  a_horiz_complement: assert property (horiz_store_phase1 != horiz_store_phase2)
    else $error("horizontal phases not complementary");
  a_exit_in_reset: assert property (sense_gate_exit |-> sense_gate_reset)
    else $error("exit pulse outside reset pulse");
  a_exit_after_store: assert property ($rose(sense_gate_exit) |-> !horiz_store_phase1)
    else $error("exit rises with phase one high");
  a_switch_exclusive: assert property (!(switch_gate_two && switch_gate_three))
    else $error("both switch gates high");
  a_switch_like_store: assert property ((switch_gate_two || switch_gate_three) |-> horiz_store_phase2)
    else $error("switch gate high outside phase two");
  a_bypass_low_gain: assert property (bypassMode && frameBusy |-> !switch_gate_three)
    else $error("multiplier path used in bypass");
  a_bypass_reset_high: assert property (bypassMode && horiz_store_phase2 |-> sense_gate_reset)
    else $error("reset low while clocking in bypass");
  a_row_reset_dip: assert property ($rose(vertRowShift) |-> resetDip)
    else $error("reset not driven low in row transfer");
  a_barrier_with_store: assert property (horiz_barrier_phase2 == horiz_store_phase2)
    else $error("phase-two barrier differs from storage");
  a_mult_complement: assert property (mult_store_phase1 != mult_store_phase2)
    else $error("multiplier storage phases overlap");
  a_mult_step_order: assert property ($fell(mult_store_phase2) |-> multStepDone)
    else $error("multiplier step edges out of order");
  a_mult_barrier_inside: assert property (!(mult_barrier_phase1 && !mult_store_phase1) && !(mult_barrier_phase2 && !mult_store_phase2))
    else $error("multiplier barrier high outside storage");
endmodule

bind ccdrt_readout_ctrl ccdrt_readout_chk u_ccdrt_readout_chk (.sys_clk(sys_clk), .reset(reset),
  .bypassMode(bypassMode), .vert_phase1_top(vert_phase1_top), .vert_phase1_bottom(vert_phase1_bottom),
  .vertRowShift(vertRowShift), .horiz_store_phase1(horiz_store_phase1), .horiz_store_phase2(horiz_store_phase2),
  .horiz_barrier_phase2(horiz_barrier_phase2), .mult_store_phase1(mult_store_phase1),
  .mult_store_phase2(mult_store_phase2), .mult_barrier_phase1(mult_barrier_phase1),
  .mult_barrier_phase2(mult_barrier_phase2),
  .sense_gate_exit(sense_gate_exit), .sense_gate_reset(sense_gate_reset), .switch_gate_two(switch_gate_two),
  .switch_gate_three(switch_gate_three), .frameBusy(frameBusy));

/* verification/ccdrt_sensor_model.sv */
/*
  Sensor plus front-end model: one packet per horizontal cycle, coded.
  Assumes the controller clocks the horizontal gates as registered levels.
*/
`timescale 1ns/10ps
module ccdrt_sensor_model
  import ccdrt_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                frameBusy,
  input  wire logic                vertRowShift,
  input  wire logic                horiz_store_phase1,
  input  wire logic                last_horiz_gate,
  input  wire logic [SAMPLE_W-1:0] sceneLevel,
  output logic      [SAMPLE_W-1:0] feSample,
  output logic                     feSampleValid
);
  int                  pixel;
  logic                lastPrev;

  // ==========================================================
  // scene
  function automatic logic [SAMPLE_W-1:0] pixelCode(input int i, input logic [SAMPLE_W-1:0] lvl);
    if (i < FIRST_ACTIVE_CYCLE)
      return 14'h0000;
    return (i % 3 == 0) ? lvl + 14'h0001 : lvl;
  endfunction

  // ==========================================================
  // summing, gain and output lag not modelled
  always @(posedge sys_clk or posedge reset)
    if (reset || vertRowShift)
    begin
      pixel <= 0;
      lastPrev <= 1'b0;
    end
    else
    begin
      lastPrev <= last_horiz_gate;
      if (last_horiz_gate && !lastPrev)
        pixel <= pixel + 1;
    end

  // code of the packet on the last gate, taken as that gate drops
  // off-window the bus shows the inverse, so stale codes cannot pass
  assign feSampleValid = last_horiz_gate && !horiz_store_phase1 && frameBusy;
  assign feSample = feSampleValid ? pixelCode(pixel + 1, sceneLevel) : ~pixelCode(pixel + 1, sceneLevel);
endmodule

/* verification/ccdrt_readout_ctrl_bench.sv */
/*
  Self-checking bench for ccdrt_readout_ctrl with a sensor model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
module ccdrt_readout_ctrl_bench;
  import ccdrt_pkg::*;
  localparam int NROWS = 2;
  logic                sys_clk, reset, frameStart, singleMode, bypassMode, feSampleValid, dec, prevP2, prevBusy;
  logic [SAMPLE_W-1:0] routeThreshold, feSample;
  logic                vert_phase1_top, vert_phase1_bottom, vertRowShift, horiz_store_phase1, horiz_store_phase2;
  logic                horiz_barrier_phase2, last_horiz_gate, sense_gate_exit, sense_gate_reset, switch_gate_two;
  logic                switch_gate_three, mult_store_phase1, mult_store_phase2, mult_barrier_phase1;
  logic                mult_barrier_phase2, blackClamp, frameBusy;
  int                  mismatches, checks, hCnt, rowCnt, vertCnt, clampCnt, lineLen;

  ccdrt_readout_ctrl #(.ROWS(NROWS)) u_ccdrt_readout_ctrl (.sys_clk(sys_clk), .reset(reset),
    .frameStart(frameStart), .singleMode(singleMode), .bypassMode(bypassMode), .routeThreshold(routeThreshold),
    .feSample(feSample), .feSampleValid(feSampleValid), .vert_phase1_top(vert_phase1_top),
    .vert_phase1_bottom(vert_phase1_bottom), .vertRowShift(vertRowShift), .horiz_store_phase1(horiz_store_phase1),
    .horiz_store_phase2(horiz_store_phase2), .horiz_barrier_phase2(horiz_barrier_phase2),
    .last_horiz_gate(last_horiz_gate), .sense_gate_exit(sense_gate_exit), .sense_gate_reset(sense_gate_reset),
    .switch_gate_two(switch_gate_two), .switch_gate_three(switch_gate_three), .mult_store_phase1(mult_store_phase1),
    .mult_store_phase2(mult_store_phase2), .mult_barrier_phase1(mult_barrier_phase1),
    .mult_barrier_phase2(mult_barrier_phase2), .blackClamp(blackClamp), .frameBusy(frameBusy));

  ccdrt_sensor_model u_ccdrt_sensor_model (.sys_clk(sys_clk), .reset(reset), .frameBusy(frameBusy),
    .vertRowShift(vertRowShift), .horiz_store_phase1(horiz_store_phase1), .last_horiz_gate(last_horiz_gate),
    .sceneLevel(routeThreshold), .feSample(feSample), .feSampleValid(feSampleValid));

  // ==========================================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic waitBusy(input logic level, input int bound);
    int n;
    for (n = 0; n < bound && frameBusy !== level; n++)
      @(negedge sys_clk);
    if (n == bound)
    begin
      mismatches++;
      summarize();
    end
  endtask

  // ==========================================================
  // line monitor: routing lag and line length
  always @(posedge sys_clk)
  begin
    lineLen = singleMode ? LINE_CYCLES_SINGLE : LINE_CYCLES_MULTI;
    if (reset)
      hCnt = 0;
    else
    begin
      vertCnt += vert_phase1_top;
      clampCnt += blackClamp;
      if (horiz_store_phase2 && !prevP2)
      begin
        hCnt++;
        dec = !bypassMode && u_ccdrt_sensor_model.pixelCode(hCnt - ROUTE_DELAY, routeThreshold) <= routeThreshold;
        if (hCnt > ROUTE_DELAY && hCnt <= lineLen)
        begin
          check(switch_gate_three, dec);
          check(switch_gate_two, !dec);
        end
      end
      if (vertRowShift || (prevBusy && !frameBusy))
      begin
        if (hCnt > 0)
          check(hCnt, lineLen);
        rowCnt += vertRowShift;
        hCnt = 0;
      end
    end
    prevP2 = horiz_store_phase2;
    prevBusy = frameBusy;
  end

  // ==========================================================
  // scenarios
  task automatic run_frame(input logic single, input logic bypass, input logic [13:0] thr, input logic poke);
    singleMode = single;
    bypassMode = bypass;
    routeThreshold = thr;
    rowCnt = 0;
    vertCnt = 0;
    clampCnt = 0;
    frameStart = 1'b1;
    @(negedge sys_clk);
    frameStart = 1'b0;
    waitBusy(1'b1, 8);
    if (poke)
    begin
      repeat (3000) @(negedge sys_clk);
      frameStart = 1'b1;
      @(negedge sys_clk);
      frameStart = 1'b0;
    end
    waitBusy(1'b0, 20000);
    repeat (6) @(negedge sys_clk);
    check(frameBusy, 1'b0);
    check(rowCnt, NROWS);
    check(vertCnt >= XFER_CYCLES, 1'b1);
    check(clampCnt, NROWS * CLAMP_LENGTH * 2);
  endtask

  task automatic reset_midframe();
    frameStart = 1'b1;
    @(negedge sys_clk);
    frameStart = 1'b0;
    waitBusy(1'b1, 8);
    repeat (600) @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(frameBusy, 1'b0);
    check(horiz_store_phase1, 1'b1);
    check(horiz_store_phase2, 1'b0);
    check(sense_gate_reset, 1'b1);
    check(switch_gate_three, 1'b0);
    reset = 1'b0;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    {reset, frameStart, singleMode, bypassMode, prevP2, prevBusy} = 6'h20;
    routeThreshold = THRESHOLD_DEFAULT;
    {mismatches, checks, hCnt, rowCnt, vertCnt, clampCnt} = '0;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    run_frame(1'b0, 1'b0, THRESHOLD_DEFAULT, 1'b1);
    run_frame(1'b1, 1'b0, 14'h0010, 1'b0);
    run_frame(1'b0, 1'b1, THRESHOLD_DEFAULT, 1'b0);
    reset_midframe();
    run_frame(1'b0, 1'b0, 14'h3FFE, 1'b0);
    summarize();
  end
endmodule
